// >>> design/debug_tap_port.v
// Debug test access port and debug interrupt front end of the core
// Functional notes
// - Low test reset forces the TAP controller to its reset state.
// - Float indication is 1 to tri-state test output, 0 to drive it.
// - Interrupt-supported strap appears in the implementation register.
// - Debug interrupt raised only on a low-to-high change between samples.
// - Debug-state output stays high for the whole of debug mode.
`include "tap_defines.vh"

module debug_tap_port #(
	parameter TAP_PRESENT = 1
) (
	input wire mclk,
	input wire rst_b,
	input wire tap_reset_n_in,
	input wire tap_clk_in,
	input wire tap_mode_sel_in,
	input wire tap_serial_in,
	output wire tap_serial_out,
	output wire test_out_float,
	input wire debug_irq_supported,
	input wire debug_irq_in,
	input wire debug_return,
	output wire debug_irq_req,
	output wire in_debug_state
);

	// ****************
	// Input synchronisers
	// ****************
	wire [5:0] raw;
	wire [5:0] syn;
	assign raw = {debug_irq_in, debug_irq_supported, tap_serial_in,
		tap_mode_sel_in, tap_clk_in, tap_reset_n_in};

	sync2 #(
		.WIDTH(6)
	) u_sync (
		.clk(mclk),
		.rst_b(rst_b),
		.d(raw),
		.q(syn)
	);

	wire trst_n_s;
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire cap_s;
	wire dint_s;
	assign trst_n_s = syn[0];
	assign tck_s = syn[1];
	assign tms_s = syn[2];
	assign tdi_s = syn[3];
	assign cap_s = syn[4];
	assign dint_s = syn[5];

	// ****************
	// Test clock edges
	// ****************
	// All TAP inputs share the same sync depth, so mode and data stay aligned
	// with the recovered clock edge.
	reg tck_prev_q;
	wire tck_rise;
	wire tck_fall;
	wire tap_on;
	assign tap_on = (TAP_PRESENT != 0);
	assign tck_rise = tap_on && tck_s && !tck_prev_q;
	assign tck_fall = tap_on && !tck_s && tck_prev_q;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			tck_prev_q <= 1'b0;
		else
			tck_prev_q <= tck_s;
	end

	// ****************
	// TAP state machine
	// ****************
	reg [3:0] state_q;
	reg [3:0] state_d;

	always @*
	begin
		case (state_q)
			`ST_RESET: state_d = tms_s ? `ST_RESET : `ST_IDLE;
			`ST_IDLE: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR: state_d = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR: state_d = tms_s ? `ST_EX1_DR : `ST_SHF_DR;
			`ST_SHF_DR: state_d = tms_s ? `ST_EX1_DR : `ST_SHF_DR;
			`ST_EX1_DR: state_d = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
			`ST_PAU_DR: state_d = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
			`ST_EX2_DR: state_d = tms_s ? `ST_UPD_DR : `ST_SHF_DR;
			`ST_UPD_DR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR: state_d = tms_s ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR: state_d = tms_s ? `ST_EX1_IR : `ST_SHF_IR;
			`ST_SHF_IR: state_d = tms_s ? `ST_EX1_IR : `ST_SHF_IR;
			`ST_EX1_IR: state_d = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
			`ST_PAU_IR: state_d = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
			`ST_EX2_IR: state_d = tms_s ? `ST_UPD_IR : `ST_SHF_IR;
			`ST_UPD_IR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			default: state_d = `ST_RESET;
		endcase
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= `ST_RESET;
		else if (!trst_n_s)
			state_q <= `ST_RESET;
		else if (tck_rise)
			state_q <= state_d;
	end

	// ****************
	// Instruction and data shift paths
	// ****************
	reg [`IR_LEN-1:0] ir_q;
	reg [`IR_LEN-1:0] ir_shift_q;
	reg [`DR_LEN-1:0] dr_shift_q;
	wire [`DR_LEN-1:0] imp_word;
	assign imp_word = `IMP_BASE | ({{(`DR_LEN-1){1'b0}}, cap_s}
		<< `IMP_CAP_BIT);

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ir_q <= `IR_RESET;
			ir_shift_q <= {`IR_LEN{1'b0}};
		end
		else if (!trst_n_s || state_q == `ST_RESET)
		begin
			ir_q <= `IR_RESET;
			ir_shift_q <= {`IR_LEN{1'b0}};
		end
		else if (tck_rise)
		begin
			case (state_q)
				`ST_CAP_IR: ir_shift_q <= `IR_CAPTURE;
				`ST_SHF_IR: ir_shift_q <= {tdi_s, ir_shift_q[`IR_LEN-1:1]};
				`ST_UPD_IR: ir_q <= ir_shift_q;
				default: ir_shift_q <= ir_shift_q;
			endcase
		end
	end

	// Unknown instructions fall back to the one-bit bypass path
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			dr_shift_q <= {`DR_LEN{1'b0}};
		else if (tck_rise && state_q == `ST_CAP_DR)
		begin
			case (ir_q)
				`IR_IDCODE: dr_shift_q <= `DEV_ID;
				`IR_IMPCODE: dr_shift_q <= imp_word;
				default: dr_shift_q <= {`DR_LEN{1'b0}};
			endcase
		end
		else if (tck_rise && state_q == `ST_SHF_DR)
		begin
			if (ir_q == `IR_IDCODE || ir_q == `IR_IMPCODE)
				dr_shift_q <= {tdi_s, dr_shift_q[`DR_LEN-1:1]};
			else
				dr_shift_q <= {{(`DR_LEN-1){1'b0}}, tdi_s};
		end
	end

	// ****************
	// Test data output, changed on the falling edge
	// ****************
	reg tdo_q;
	reg float_q;
	wire shifting;
	assign shifting = (state_q == `ST_SHF_DR) || (state_q == `ST_SHF_IR);

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tdo_q <= 1'b0;
			float_q <= 1'b1;
		end
		else if (!trst_n_s || !tap_on)
		begin
			tdo_q <= 1'b0;
			float_q <= 1'b1;
		end
		else if (tck_fall)
		begin
			tdo_q <= (state_q == `ST_SHF_IR) ? ir_shift_q[0]
				: dr_shift_q[0];
			float_q <= !shifting;
		end
	end

	assign tap_serial_out = tdo_q;
	assign test_out_float = float_q;

	// ****************
	// Debug interrupt and debug mode
	// ****************
	// Sampled on the CPU clock; a level held high raises only one request.
	reg dint_prev_q;
	reg req_q;
	reg dbg_q;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dint_prev_q <= 1'b0;
			req_q <= 1'b0;
			dbg_q <= 1'b0;
		end
		else
		begin
			dint_prev_q <= dint_s;
			req_q <= dint_s && !dint_prev_q;
			// Entry wins over a return in the same cycle
			if (req_q)
				dbg_q <= 1'b1;
			else if (debug_return)
				dbg_q <= 1'b0;
		end
	end

	assign debug_irq_req = req_q;
	assign in_debug_state = dbg_q;

endmodule // debug_tap_port

// >>> design/sync2.v
// Two-stage synchroniser for a group of asynchronous inputs
module sync2 #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst_b,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end
				else
				begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate

endmodule // sync2

// >>> design/tap_defines.vh
// Constants for the debug test access port block
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH

// ****************
// TAP state codes
// ****************
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHF_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SHF_IR 4'hB
`define ST_EX1_IR 4'hC
`define ST_PAU_IR 4'hD
`define ST_EX2_IR 4'hE
`define ST_UPD_IR 4'hF

// ****************
// Instruction register
// ****************
`define IR_LEN 5
`define IR_CAPTURE 5'h01
`define IR_IDCODE 5'h01
`define IR_IMPCODE 5'h03
`define IR_BYPASS 5'h1F
`define IR_RESET 5'h01

// ****************
// Data registers
// ****************
`define DR_LEN 32
`define IMP_CAP_BIT 24
`define IMP_BASE 32'h00000000
// Identification value is arbitrary
`define DEV_ID 32'h00000001

`endif

// >>> tb/debug_tap_port_chk.sv
// Assertion checker for the debug test access port
module debug_tap_port_chk (
	input wire mclk,
	input wire rst_b,
	input wire tap_reset_n_in,
	input wire tap_clk_in,
	input wire tap_serial_out,
	input wire test_out_float,
	input wire debug_irq_in,
	input wire debug_return,
	input wire debug_irq_req,
	input wire in_debug_state
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Checks
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_req_pulse: assert property
		(debug_irq_req |=> !debug_irq_req) else $error("long req");
	a_req_cause: assert property
		(debug_irq_req |-> $past(debug_irq_in, 3)) else $error("no input");
	a_req_edge: assert property
		(debug_irq_req |-> !$past(debug_irq_in, 4)) else $error("no edge");
	a_dbg_enter: assert property
		(debug_irq_req |=> in_debug_state) else $error("no entry");
	a_dbg_hold: assert property
		(in_debug_state && !debug_return |=> in_debug_state)
		else $error("left early");
	a_trst_idle: assert property
		(!tap_reset_n_in [*5] |-> test_out_float && !tap_serial_out)
		else $error("trst ignored");
	// Outputs move only after a falling test clock edge or on a low test reset
	a_tdo_steady: assert property
		(tap_clk_in |-> $stable({tap_serial_out, test_out_float}))
		else $error("tdo moved");
	a_float_fall: assert property
		($fell(test_out_float) |-> !$past(tap_clk_in, 2) &&
		$past(tap_clk_in, 7)) else $error("float fell");
	c_req: cover property (debug_irq_req);
	c_drive: cover property ($fell(test_out_float));
	c_leave: cover property ($fell(in_debug_state));
endmodule // debug_tap_port_chk

bind debug_tap_port debug_tap_port_chk i_debug_tap_port_chk (.*);

// >>> tb/debug_tap_port_test.sv
// Self-checking testbench for the debug test access port
`include "tap_defines.vh"
module debug_tap_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'h0, rst_b = 1'h0, debug_irq_supported = 1'h0;
	logic debug_irq_in = 1'h0, debug_return = 1'h0, z, f;
	logic [31:0] r;
	wire tap_reset_n_in, tap_clk_in, tap_mode_sel_in, tap_serial_in;
	wire tap_serial_out, test_out_float, debug_irq_req, in_debug_state;
	int failures = 0, samples_checked = 0, cyc = 0, nreq = 0;
	debug_tap_port i_debug_tap_port (.*);
	tap_probe i_tap_probe (.tck(tap_clk_in), .tms(tap_mode_sel_in),
		.tdi(tap_serial_in), .trst_n(tap_reset_n_in), .tdo(tap_serial_out),
		.tdo_float(test_out_float));
	always #12.5 mclk = ~mclk;
	always @(negedge mclk)
	begin
		cyc++;
		nreq += debug_irq_req === 1'h1;
		if (cyc == 8000)
		begin
			failures++;
			end_sim;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task nav(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++)
			i_tap_probe.step(b[i], 1'h0, z, z);
	endtask
	task t_reset;
		chk("idle", 4'h1, {debug_irq_req, in_debug_state, tap_serial_out,
			test_out_float});
		$display("reset done");
	endtask
	task t_irq;
		repeat (2)
		begin
			debug_irq_in = 1'h1;
			tick(10);
			debug_irq_in = 1'h0;
			tick(10);
		end
		chk("reqs", 2, nreq);
		chk("dbg", 1'h1, in_debug_state);
		debug_return = 1'h1;
		tick(1);
		debug_return = 1'h0;
		tick(3);
		chk("ret", 1'h0, in_debug_state);
		$display("irq done");
	endtask
	task t_idcode;
		nav(16'h005F, 9);
		f = 1'h0;
		i_tap_probe.shift(32, 32'h0, r, f);
		chk("id", `DEV_ID, r);
		chk("drive", 1'h0, f);
		#100 chk("float", 1'h1, test_out_float);
		$display("idcode done");
	endtask
	task t_impcode;
		for (int s = 0; s < 2; s++)
		begin
			tick(1);
			debug_irq_supported = s[0];
			nav(16'h00DF, 10);
			i_tap_probe.shift(5, `IR_IMPCODE, r, z);
			chk("ircap", `IR_CAPTURE, r[4:0]);
			nav(16'h0005, 5);
			i_tap_probe.shift(32, 32'h0, r, z);
			chk("imp", `IMP_BASE | (s << `IMP_CAP_BIT), r);
		end
		$display("impcode done");
	endtask
	task t_trst;
		nav(16'h0003, 7);
		i_tap_probe.trst_n = 1'h0;
		#300 chk("trst", 2'h1, {tap_serial_out, test_out_float});
		i_tap_probe.trst_n = 1'h1;
		#200 nav(16'h0002, 4);
		i_tap_probe.shift(32, 32'h0, r, z);
		chk("irrst", `DEV_ID, r);
		$display("trst done");
	endtask
	// One-bit path: a captured 0 first, then the pattern one bit late
	task t_bypass;
		nav(16'h00DF, 10);
		i_tap_probe.shift(5, `IR_BYPASS, r, z);
		nav(16'h0005, 5);
		i_tap_probe.shift(8, 32'h000000A5, r, z);
		chk("bypass", 8'h4A, r[7:0]);
		$display("bypass done");
	endtask
	task end_sim;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		tick(5);
		rst_b = 1'h1;
		tick(2);
		t_reset;
		t_irq;
		t_idcode;
		t_impcode;
		t_trst;
		t_bypass;
		end_sim;
	end
endmodule // debug_tap_port_test

// >>> tb/tap_probe.sv
// Behavioural debug probe on the test access port
module tap_probe (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire tdo,
	input wire tdo_float
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Probe
	// ****
	initial
	begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		trst_n = 1'h0;
		#500 trst_n = 1'h1;
	end
	// Test clock stands low between calls; output read just before rise
	task step(input logic m, input logic d, output logic o, inout logic z);
		tms = m;
		tdi = d;
		// Chip buffer floats when told to; a floating line reads inverted
		#100 o = tdo_float ? ~tdo : tdo;
		z = z | tdo_float;
		tck = 1'h1;
		#100 tck = 1'h0;
	endtask
	task shift(input int n, input logic [31:0] v, output logic [31:0] r,
		inout logic f);
		for (int i = 0; i < n; i++)
			step(i == n - 1, v[i], r[i], f);
	endtask
endmodule // tap_probe
